/* File: core/ues_endpoint_select.v */
/*
 * Endpoint selection and per-endpoint configuration with a classic
 * Wishbone register slave and a status/strobe port to the serial engine.
 * Assumes the serial engine runs on clk_i and gives one-cycle strobes.
 */
// The Wishbone register port is this design's own decision.
`include "ues_map.vh"

module ues_endpoint_select (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [9:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        usb_bus_reset_i,
    input  wire [3:0]  sie_ep_i,
    input  wire        sie_data_accept_i,
    input  wire        sie_data1_i,
    input  wire        sie_out_push_i,
    input  wire [7:0]  sie_out_data_i,
    input  wire        sie_out_done_i,
    input  wire        sie_in_pop_i,
    input  wire        sie_in_sent_i,
    input  wire        sie_in_acked_i,
    output wire [7:0]  sie_in_data_o,
    output wire        ep_enabled_o,
    output wire        ep_dir_in_o,
    output wire [1:0]  ep_type_o,
    output wire        ep_toggle_o,
    output wire        out_refuse_o,
    output wire        in_ready_o
);

    reg  [3:0]             ep_index_field_reg;
    reg  [7:0]             ctl_reg [0:`UES_NUM_EP-1];
    reg  [6:0]             toggle_track_bit_reg;
    reg  [6:0]             out_bank0_received_reg;
    reg  [6:0]             in_packet_ready_reg;
    reg  [31:0]            rd_next;
    wire                   req;
    wire                   wr_stb;
    wire                   rd_stb;
    wire [7:0]             reg_idx;
    wire                   sel_ok;
    wire                   sie_ok;
    wire [2:0]             sel_ep;
    wire [2:0]             sie_ep;
    wire [7:0]             sel_ctl;
    wire [7:0]             sie_ctl;
    wire [7:0]             fifo_cpu_data;
    wire [`UES_CNT_W-1:0]  fifo_count;
    wire                   out_flush;
    wire                   in_flush;
    integer                k;

    // ============================================================
    // Helpers
    function ep_valid;
        input [3:0] ep;
        begin
            ep_valid = (ep <= `UES_LAST_EP);
        end
    endfunction

    function is_iso;
        input [7:0] ctl;
        begin
            is_iso = (ctl[1:0] == `UES_TYPE_ISO);
        end
    endfunction

    // ============================================================
    // Bus decode; the request is acted on once, in the cycle before ack
    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb  = req && wb_we_i && wb_sel_i[0];
    assign rd_stb  = req && !wb_we_i;
    assign reg_idx = wb_adr_i[9:2];

    // Selection is combinational from the stored index, so a new index
    // steers the next access without any settling cycle.
    assign sel_ok  = ep_valid(ep_index_field_reg);
    assign sel_ep  = ep_index_field_reg[2:0];
    assign sel_ctl = sel_ok ? ctl_reg[sel_ep] : 8'h00;
    assign sie_ok  = ep_valid(sie_ep_i);
    assign sie_ep  = sie_ep_i[2:0];
    assign sie_ctl = sie_ok ? ctl_reg[sie_ep] : 8'h00;

    // ============================================================
    // Index register
    always @(posedge clk_i) begin
        if (rst_i)
            ep_index_field_reg <= 4'h0;
        else if (wr_stb && reg_idx == `UES_IDX_SELECT)
            ep_index_field_reg <= wb_dat_i[3:0];
    end

    // ============================================================
    // Control registers
    always @(posedge clk_i) begin
        if (rst_i || usb_bus_reset_i) begin
            ctl_reg[0] <= `UES_CTL_RST_EP0;
            for (k = 1; k < `UES_NUM_EP; k = k + 1)
                ctl_reg[k] <= `UES_CTL_RST_EPN;
        end else if (wr_stb && reg_idx == `UES_IDX_CONTROL && sel_ok) begin
            // Reserved bits and the toggle are never stored
            ctl_reg[sel_ep] <= wb_dat_i[7:0] & `UES_CTL_WMASK;
            if (sel_ep == 3'h0)
                ctl_reg[0] <= {wb_dat_i[7], 5'h00, `UES_TYPE_CONTROL};
        end
    end

    // ============================================================
    // Data toggle tracking
    always @(posedge clk_i) begin
        if (rst_i || usb_bus_reset_i)
            toggle_track_bit_reg <= 7'h00;
        else if (sie_data_accept_i && sie_ok)
            toggle_track_bit_reg[sie_ep] <= !sie_data1_i;
    end

    // ============================================================
    // Status flags; a hardware set wins over a firmware clear in the same cycle
    // Only clearing a set out-received frees the bank; setting in-ready keeps the IN bytes
    assign out_flush = wr_stb && reg_idx == `UES_IDX_STATUS && sel_ok
                       && !wb_dat_i[`UES_STA_OUT_B0] && out_bank0_received_reg[sel_ep];
    assign in_flush  = sie_ok && ((sie_in_sent_i && is_iso(sie_ctl))
                       || (sie_in_acked_i && !is_iso(sie_ctl)));

    always @(posedge clk_i) begin
        if (rst_i || usb_bus_reset_i) begin
            out_bank0_received_reg <= 7'h00;
            in_packet_ready_reg    <= 7'h00;
        end else begin
            if (wr_stb && reg_idx == `UES_IDX_STATUS && sel_ok) begin
                if (!wb_dat_i[`UES_STA_OUT_B0])
                    out_bank0_received_reg[sel_ep] <= 1'b0;
                in_packet_ready_reg[sel_ep] <= wb_dat_i[`UES_STA_IN_READY];
            end
            if (in_flush)
                in_packet_ready_reg[sie_ep] <= 1'b0;
            if (sie_out_done_i && sie_ok && !out_refuse_o)
                out_bank0_received_reg[sie_ep] <= 1'b1;
        end
    end

    // ============================================================
    // Serial engine view of the endpoint it is addressing
    assign ep_enabled_o = sie_ctl[`UES_CTL_EN];
    assign ep_type_o    = sie_ctl[1:0];
    assign ep_dir_in_o  = (sie_ctl[1:0] != `UES_TYPE_CONTROL)
                          && sie_ctl[`UES_CTL_DIR];
    assign ep_toggle_o  = sie_ok && toggle_track_bit_reg[sie_ep];
    // Disabled endpoints refuse too, so a stray packet never lands in a buffer
    assign out_refuse_o = !sie_ok || !sie_ctl[`UES_CTL_EN]
                          || (out_bank0_received_reg[sie_ep] && !is_iso(sie_ctl));
    assign in_ready_o   = sie_ok && in_packet_ready_reg[sie_ep];

    // ============================================================
    // Endpoint buffers; a flush follows each freed bank, except an IN bank freed in the same cycle as an OUT bank
    ues_ep_fifo u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i || usb_bus_reset_i),
        .cpu_ep_i    (sel_ep),
        .cpu_push_i  (wr_stb && reg_idx == `UES_IDX_FIFO && sel_ok),
        .cpu_pop_i   (rd_stb && reg_idx == `UES_IDX_FIFO && sel_ok),
        .cpu_data_i  (wb_dat_i[7:0]),
        .cpu_data_o  (fifo_cpu_data),
        .cpu_count_o (fifo_count),
        .sie_ep_i    (sie_ep),
        .sie_push_i  (sie_out_push_i && sie_ok && !out_refuse_o),
        .sie_pop_i   (sie_in_pop_i && sie_ok),
        .sie_data_i  (sie_out_data_i),
        .sie_data_o  (sie_in_data_o),
        .flush_i     (out_flush || in_flush),
        .flush_ep_i  (out_flush ? sel_ep : sie_ep)
    );

    // ============================================================
    // Read mux
    always @* begin
        rd_next = 32'h0000_0000;
        case (reg_idx)
            `UES_IDX_SELECT:   rd_next[7:0] = {4'h0, ep_index_field_reg};
            `UES_IDX_CONTROL:  rd_next[7:0] = {sel_ctl[7], 3'h0,
                                    sel_ok && toggle_track_bit_reg[sel_ep],
                                    sel_ctl[2:0]};
            `UES_IDX_STATUS:   rd_next[7:0] = sel_ok ?
                                    {3'h0, in_packet_ready_reg[sel_ep], 2'h0,
                                     out_bank0_received_reg[sel_ep], 1'b0} : 8'h00;
            `UES_IDX_FIFO:     rd_next[7:0] = sel_ok ? fifo_cpu_data : 8'h00;
            `UES_IDX_COUNT_LO: rd_next[7:0] = sel_ok ? {2'h0, fifo_count} : 8'h00;
            `UES_IDX_COUNT_HI: rd_next[7:0] = 8'h00;
            default:           rd_next = 32'h0000_0000;
        endcase
    end

    // ============================================================
    // Ack one cycle after the request, dropped the cycle after
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (rd_stb)
                wb_dat_o <= rd_next;
        end
    end

endmodule

/* File: core/ues_ep_fifo.v */
/*
 * Per-endpoint byte buffers with a CPU port and a serial-engine port.
 * Assumes both ports never push to or pop from the same endpoint in one
 * cycle; the owner of the endpoint direction keeps to that.
 */
`include "ues_map.vh"

module ues_ep_fifo (
    input  wire                   clk_i,
    input  wire                   rst_i,
    input  wire [2:0]             cpu_ep_i,
    input  wire                   cpu_push_i,
    input  wire                   cpu_pop_i,
    input  wire [7:0]             cpu_data_i,
    output wire [7:0]             cpu_data_o,
    output wire [`UES_CNT_W-1:0]  cpu_count_o,
    input  wire [2:0]             sie_ep_i,
    input  wire                   sie_push_i,
    input  wire                   sie_pop_i,
    input  wire [7:0]             sie_data_i,
    output wire [7:0]             sie_data_o,
    input  wire                   flush_i,
    input  wire [2:0]             flush_ep_i
);

    reg [7:0]            mem [0:`UES_NUM_EP*`UES_FIFO_DEPTH-1];
    reg [`UES_CNT_W-1:0] wp_reg [0:`UES_NUM_EP-1];
    reg [`UES_CNT_W-1:0] rp_reg [0:`UES_NUM_EP-1];
    integer              i;

    localparam [`UES_CNT_W-1:0] DEPTH = `UES_FIFO_DEPTH;

    // Fill level is taken modulo the pointer width, so a wrapped pair still counts right
    function [`UES_CNT_W-1:0] fill;
        input [2:0] ep;
        begin
            fill = wp_reg[ep] - rp_reg[ep];
        end
    endfunction

    function has_room;
        input [2:0] ep;
        begin
            has_room = (fill(ep) != DEPTH);
        end
    endfunction

    function [7:0] slot;
        input [2:0]            ep;
        input [`UES_CNT_W-1:0] ptr;
        begin
            slot = {ep, ptr[4:0]};
        end
    endfunction

    assign cpu_data_o  = mem[slot(cpu_ep_i, rp_reg[cpu_ep_i])];
    assign sie_data_o  = mem[slot(sie_ep_i, rp_reg[sie_ep_i])];
    assign cpu_count_o = fill(cpu_ep_i);

    // ============================================================
    // Pointers; a full buffer drops further pushes, an empty one ignores pops
    always @(posedge clk_i) begin
        if (cpu_push_i && has_room(cpu_ep_i))
            mem[slot(cpu_ep_i, wp_reg[cpu_ep_i])] <= cpu_data_i;
        if (sie_push_i && has_room(sie_ep_i))
            mem[slot(sie_ep_i, wp_reg[sie_ep_i])] <= sie_data_i;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            for (i = 0; i < `UES_NUM_EP; i = i + 1) begin
                wp_reg[i] <= {`UES_CNT_W{1'b0}};
                rp_reg[i] <= {`UES_CNT_W{1'b0}};
            end
        end else begin
            if (cpu_push_i && has_room(cpu_ep_i))
                wp_reg[cpu_ep_i] <= wp_reg[cpu_ep_i] + 1'b1;
            if (sie_push_i && has_room(sie_ep_i))
                wp_reg[sie_ep_i] <= wp_reg[sie_ep_i] + 1'b1;
            if (cpu_pop_i && wp_reg[cpu_ep_i] != rp_reg[cpu_ep_i])
                rp_reg[cpu_ep_i] <= rp_reg[cpu_ep_i] + 1'b1;
            if (sie_pop_i && wp_reg[sie_ep_i] != rp_reg[sie_ep_i])
                rp_reg[sie_ep_i] <= rp_reg[sie_ep_i] + 1'b1;
            if (flush_i) begin
                wp_reg[flush_ep_i] <= {`UES_CNT_W{1'b0}};
                rp_reg[flush_ep_i] <= {`UES_CNT_W{1'b0}};
            end
        end
    end

endmodule

/* File: core/ues_map.vh */
/*
 * Constants of the endpoint select and configuration block: register
 * indices, field positions, reset values and encodings.
 * Assumes a Wishbone slave with 32-bit words; byte address = 4 * index.
 */
`ifndef UES_MAP_VH
`define UES_MAP_VH

// ============================================================
// Register indices
`define UES_IDX_SELECT      8'hC7
`define UES_IDX_STATUS      8'hCE
`define UES_IDX_FIFO        8'hCF
`define UES_IDX_CONTROL     8'hD4
`define UES_IDX_COUNT_LO    8'hE2
`define UES_IDX_COUNT_HI    8'hE3

// ============================================================
// Fields and values
`define UES_NUM_EP          7
`define UES_LAST_EP         4'h6
`define UES_FIFO_DEPTH      32
`define UES_CNT_W           6
`define UES_CTL_EN          7
`define UES_CTL_TOGGLE      3
`define UES_CTL_DIR         2
`define UES_STA_IN_READY    4
`define UES_STA_OUT_B0      1
`define UES_CTL_WMASK       8'h87
`define UES_CTL_RST_EP0     8'h80
`define UES_CTL_RST_EPN     8'h00
`define UES_TYPE_CONTROL    2'h0
`define UES_TYPE_ISO        2'h1
`define UES_TYPE_BULK       2'h2
`define UES_TYPE_INTR       2'h3

`endif

/* File: verification/tb_top.sv */
/* Self-checking bench of the endpoint select block.
   Assumes the engine model and checker files are compiled with it. */
`include "ues_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, bus_rst = 1'b0;
    logic [9:0]  adr = 10'h000;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic        ack, en, dir, tgl, refuse, rdy;
    logic [1:0]  typ;
    logic [3:0]  s_ep;
    logic [6:0]  s;
    logic [7:0]  s_dat, in_dat, c;
    int          bad_count = 0, compares = 0;
    always #5 clk_i = ~clk_i;
    ues_sie_model i_ues_sie_model (.clk_i(clk_i), .ep_o(s_ep), .strobe_o(s), .data_o(s_dat));
    ues_endpoint_select i_ues_endpoint_select (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .usb_bus_reset_i(bus_rst),
        .sie_ep_i(s_ep), .sie_data_accept_i(s[6]), .sie_data1_i(s[5]), .sie_out_push_i(s[4]),
        .sie_out_data_i(s_dat), .sie_out_done_i(s[3]), .sie_in_pop_i(s[2]),
        .sie_in_sent_i(s[1]), .sie_in_acked_i(s[0]), .sie_in_data_o(in_dat),
        .ep_enabled_o(en), .ep_dir_in_o(dir), .ep_type_o(typ), .ep_toggle_o(tgl),
        .out_refuse_o(refuse), .in_ready_o(rdy));
    // ============================================================
    // Shared tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        {cyc, stb, we, sel} <= {1'b1, 1'b1, w, 4'h1};
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        @(posedge clk_i);
        while (ack !== 1'b1) @(posedge clk_i);
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic rd(input string n, input logic [7:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        chk(n, q, {24'h0, exp});
    endtask
    task automatic engine(input logic [3:0] ep, input logic [6:0] st);
        i_ues_sie_model.pulse(ep, st, 8'h00);
        @(negedge clk_i);
    endtask
    task automatic end_of_test;
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ============================================================
    // Scenarios
    task automatic t_config;
        for (int e = 0; e < 7; e++) begin
            wb(1'b1, `UES_IDX_SELECT, 8'hF0 | e[7:0]);
            rd("reset ctl", `UES_IDX_CONTROL, e == 0 ? 8'h80 : 8'h00);
        end
        for (int e = 1; e < 7; e++) begin
            c = {e != 6, 4'b1110, e > 3, e[1:0]};
            wb(1'b1, `UES_IDX_SELECT, 8'hF0 | e[7:0]);
            wb(1'b1, `UES_IDX_CONTROL, c);
            rd("index", `UES_IDX_SELECT, e[7:0]);
            rd("ctl", `UES_IDX_CONTROL, c & 8'h87);
            engine(e[3:0], 7'h00);
            chk("enabled", en, e != 6);
            chk("type", typ, e[1:0]);
            chk("dir", dir, e > 4);
        end
        wb(1'b1, `UES_IDX_SELECT, 8'h00);
        wb(1'b1, `UES_IDX_CONTROL, 8'h83);
        rd("ep0 ctl", `UES_IDX_CONTROL, 8'h80);
        wb(1'b1, `UES_IDX_SELECT, 8'h07);
        wb(1'b1, `UES_IDX_CONTROL, 8'h81);
        rd("ep7 ctl", `UES_IDX_CONTROL, 8'h00);
        rd("unmapped", 8'h10, 8'h00);
    endtask
    task automatic t_toggle_out;
        engine(4'h2, 7'h40);
        chk("toggle pin high", tgl, 1'b1);
        wb(1'b1, `UES_IDX_SELECT, 8'h02);
        rd("toggle data0", `UES_IDX_CONTROL, 8'h8A);
        engine(4'h2, 7'h60);
        chk("toggle pin low", tgl, 1'b0);
        rd("toggle data1", `UES_IDX_CONTROL, 8'h82);
        i_ues_sie_model.out_pkt(4'h2, 3, 8'h10);
        @(negedge clk_i);
        chk("refuse full", refuse, 1'b1);
        rd("status", `UES_IDX_STATUS, 8'h02);
        i_ues_sie_model.out_pkt(4'h2, 1, 8'hEE);
        rd("count", `UES_IDX_COUNT_LO, 8'h03);
        for (int i = 0; i < 3; i++) rd("fifo", `UES_IDX_FIFO, 8'h10 + i[7:0]);
        wb(1'b1, `UES_IDX_STATUS, 8'h00);
        engine(4'h2, 7'h00);
        chk("refuse cleared", refuse, 1'b0);
        i_ues_sie_model.out_pkt(4'h1, 1, 8'h55);
        @(negedge clk_i);
        chk("iso refuse", refuse, 1'b0);
    endtask
    task automatic t_in;
        wb(1'b1, `UES_IDX_SELECT, 8'h05);
        wb(1'b1, `UES_IDX_STATUS, 8'h10);
        engine(4'h5, 7'h00);
        chk("iso set", rdy, 1'b1);
        engine(4'h5, 7'h02);
        chk("iso ready", rdy, 1'b0);
        wb(1'b1, `UES_IDX_SELECT, 8'h03);
        wb(1'b1, `UES_IDX_FIFO, 8'hA5);
        wb(1'b1, `UES_IDX_STATUS, 8'h10);
        rd("in count", `UES_IDX_COUNT_LO, 8'h01);
        engine(4'h3, 7'h00);
        chk("in byte", in_dat, 8'hA5);
        engine(4'h3, 7'h04);
        engine(4'h3, 7'h02);
        chk("sent ready", rdy, 1'b1);
        engine(4'h3, 7'h01);
        chk("acked ready", rdy, 1'b0);
    endtask
    task automatic t_bus_reset;
        wb(1'b1, `UES_IDX_SELECT, 8'h00);
        wb(1'b1, `UES_IDX_CONTROL, 8'h00);
        rd("ep0 off", `UES_IDX_CONTROL, 8'h00);
        @(posedge clk_i) bus_rst <= 1'b1;
        repeat (2) @(posedge clk_i);
        bus_rst <= 1'b0;
        rd("ep0 bus reset", `UES_IDX_CONTROL, 8'h80);
        wb(1'b1, `UES_IDX_SELECT, 8'h02);
        rd("ep2 bus reset", `UES_IDX_CONTROL, 8'h00);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_config();
        t_toggle_out();
        t_in();
        t_bus_reset();
        end_of_test();
    end
    // Whole run is well under a thousand bus cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        end_of_test();
    end
endmodule

/* File: verification/ues_props.sv */
/* Checker of the endpoint select block, bound to its ports.
   Assumes one clock and a synchronous active-high reset. */
`include "ues_map.vh"
module ues_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        usb_bus_reset_i,
    input wire logic [3:0]  sie_ep_i,
    input wire logic        sie_data_accept_i,
    input wire logic        sie_data1_i,
    input wire logic        sie_out_done_i,
    input wire logic        sie_in_sent_i,
    input wire logic        ep_enabled_o,
    input wire logic        ep_dir_in_o,
    input wire logic [1:0]  ep_type_o,
    input wire logic        ep_toggle_o,
    input wire logic        out_refuse_o,
    input wire logic        in_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd = req && !wb_we_i;
    // Engine strobes only count on real endpoints outside a bus reset
    wire ok_ep = (sie_ep_i <= `UES_LAST_EP) && !usb_bus_reset_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ============================================================
    // Register bus
    a_ack_next: assert property (req |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_index_upper: assert property (rd && wb_adr_i[9:2] == `UES_IDX_SELECT
        |=> wb_dat_o[7:4] == 4'h0) else $error("index top bits set");
    a_ctl_reserved: assert property (rd && wb_adr_i[9:2] == `UES_IDX_CONTROL
        |=> wb_dat_o[6:4] == 3'h0) else $error("control reserved bits set");
    // ============================================================
    // Engine side
    a_toggle_set: assert property (sie_data_accept_i && !sie_data1_i && ok_ep
        ##1 $stable(sie_ep_i) |-> ep_toggle_o) else $error("toggle not set");
    a_toggle_clr: assert property (sie_data_accept_i && sie_data1_i && ok_ep
        ##1 $stable(sie_ep_i) |-> !ep_toggle_o) else $error("toggle not cleared");
    a_dir_control: assert property (ep_type_o == `UES_TYPE_CONTROL
        |-> !ep_dir_in_o) else $error("direction on control type");
    a_ep0_control: assert property (sie_ep_i == 4'h0
        |-> ep_type_o == `UES_TYPE_CONTROL) else $error("endpoint zero not control");
    a_refuse_bad: assert property (sie_ep_i > `UES_LAST_EP || !ep_enabled_o
        |-> out_refuse_o) else $error("out accepted on bad endpoint");
    a_out_held: assert property (ok_ep && sie_out_done_i && !out_refuse_o
        && ep_type_o != `UES_TYPE_ISO ##1 $stable(sie_ep_i) |-> out_refuse_o)
        else $error("out not refused after packet");
    a_iso_in_clr: assert property (ok_ep && sie_in_sent_i && ep_type_o == `UES_TYPE_ISO
        ##1 $stable(sie_ep_i) |-> !in_ready_o) else $error("iso in ready kept");
    a_ep0_reset: assert property ($past(rst_i || usb_bus_reset_i) && sie_ep_i == 4'h0
        |-> ep_enabled_o) else $error("endpoint zero disabled after reset");
endmodule
bind ues_endpoint_select ues_props i_ues_props (.*);

/* File: verification/ues_sie_model.sv */
/* Behavioural serial engine standing for the host side.
   Assumes the bench calls its tasks one at a time. */
module ues_sie_model (
    input  wire logic       clk_i,
    output logic [3:0]      ep_o,
    output logic [6:0]      strobe_o,
    output logic [7:0]      data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // strobe_o: 6 accept, 5 data1, 4 push, 3 done, 2 pop, 1 sent, 0 acked
    initial begin
        ep_o = 4'h0;
        strobe_o = 7'h00;
        data_o = 8'h00;
    end
    // One strobe cycle; the data line shows no stale byte once released
    task automatic pulse(input logic [3:0] ep, input logic [6:0] s, input logic [7:0] d);
        @(posedge clk_i);
        ep_o <= ep;
        strobe_o <= s;
        data_o <= s[4] ? d : ~data_o;
        @(posedge clk_i);
        strobe_o <= 7'h00;
        data_o <= s[4] ? ~d : ~data_o;
    endtask
    task automatic out_pkt(input logic [3:0] ep, input int n, input logic [7:0] first);
        for (int i = 0; i < n; i++) pulse(ep, 7'h10, first + i[7:0]);
        pulse(ep, 7'h08, 8'h00);
    endtask
endmodule
